// ===== design/jct_top.sv
// Job-cycle timer, ejector queue and result telegram framer
//
// The implementer's own choices: the register offsets and strobed register access.
`include "jct_consts.svh"

module jct_top #(
    parameter int MS_CYCLES = `JCT_MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic trigger_pin,
    input wire logic eval_done,
    input wire logic eval_ok,
    input wire logic [7:0] det_done,
    input wire logic [7:0] det_result,
    input wire logic [7:0] dig_outs,
    input wire logic [7:0] log_outs,
    input wire logic [15:0] val_data,
    input wire logic resp_end,
    input wire logic tx_ready,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic job_start,
    output logic job_abort,
    output logic [6:0] val_sel,
    output jct_pkg::jct_out_t pins,
    output jct_pkg::jct_tx_t tx
);
    import jct_pkg::*;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [5:0] ctrl_ff;
    logic [8:0] fields_ff;
    logic [15:0] min_ff, max_ff, ej_dly_ff, ej_len_ff;
    logic [25:0] start_ff, trail_ff, sep_ff, eot_ff;
    logic [7:0] jobno_ff;
    logic [11:0] entry_ff [`JCT_N_ENTRY];
    logic [31:0] rdata_ff;
    logic ovf_ff;
    logic [15:0] exec_ff;
    logic ready_ff, valid_ff, ok_ff, abort_ff, eject_ff;
    logic [7:0] det_ff;
    logic [4:0] q_cnt_ff;
    logic wr_hit;

    assign wr_hit = reg_wr;

    // Software writable configuration
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_ff <= `JCT_CTRL_RST;
            fields_ff <= `JCT_FIELDS_RST;
            min_ff <= 16'h0000;
            max_ff <= 16'h0000;
            ej_dly_ff <= 16'h0000;
            ej_len_ff <= 16'h0001;
            start_ff <= 26'h0000000;
            trail_ff <= 26'h0000000;
            sep_ff <= 26'h0000000;
            eot_ff <= 26'h0000000;
            jobno_ff <= 8'h00;
        end else if (wr_hit) begin
            unique case (reg_addr)
                `JCT_REG_CTRL: ctrl_ff <= reg_wdata[5:0];
                `JCT_REG_FIELDS: fields_ff <= reg_wdata[8:0];
                `JCT_REG_MIN_MS: min_ff <= reg_wdata[15:0];
                `JCT_REG_MAX_MS: max_ff <= reg_wdata[15:0];
                `JCT_REG_EJECT: begin
                    ej_dly_ff <= reg_wdata[15:0];
                    ej_len_ff <= reg_wdata[31:16];
                end
                `JCT_REG_START: start_ff <= reg_wdata[25:0];
                `JCT_REG_TRAIL: trail_ff <= reg_wdata[25:0];
                `JCT_REG_SEP: sep_ff <= reg_wdata[25:0];
                `JCT_REG_EOT: eot_ff <= reg_wdata[25:0];
                `JCT_REG_JOBNO: jobno_ff <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Payload list, one word per entry
    genvar ge;
    generate
        for (ge = 0; ge < `JCT_N_ENTRY; ge++) begin : g_entry
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    entry_ff[ge] <= 12'h000;
                end else if (reg_wr && reg_addr == `JCT_REG_ENTRY0 + 8'(4 * ge)) begin
                    entry_ff[ge] <= reg_wdata[11:0];
                end
            end
        end
    endgenerate

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_ff <= 32'h00000000;
            unique case (reg_addr)
                `JCT_REG_CTRL: rdata_ff <= {26'h0, ctrl_ff};
                `JCT_REG_FIELDS: rdata_ff <= {23'h0, fields_ff};
                `JCT_REG_MIN_MS: rdata_ff <= {16'h0, min_ff};
                `JCT_REG_MAX_MS: rdata_ff <= {16'h0, max_ff};
                `JCT_REG_EJECT: rdata_ff <= {ej_len_ff, ej_dly_ff};
                `JCT_REG_START: rdata_ff <= {6'h0, start_ff};
                `JCT_REG_TRAIL: rdata_ff <= {6'h0, trail_ff};
                `JCT_REG_SEP: rdata_ff <= {6'h0, sep_ff};
                `JCT_REG_EOT: rdata_ff <= {6'h0, eot_ff};
                `JCT_REG_JOBNO: rdata_ff <= {24'h0, jobno_ff};
                `JCT_REG_STATUS: rdata_ff <= {19'h0, q_cnt_ff, 3'h0, ovf_ff, abort_ff, ok_ff, valid_ff, ready_ff};
                `JCT_REG_EXEC: rdata_ff <= {16'h0, exec_ff};
                `JCT_REG_ENTRY0 + 8'h00: rdata_ff <= {20'h0, entry_ff[0]};
                `JCT_REG_ENTRY0 + 8'h04: rdata_ff <= {20'h0, entry_ff[1]};
                `JCT_REG_ENTRY0 + 8'h08: rdata_ff <= {20'h0, entry_ff[2]};
                `JCT_REG_ENTRY0 + 8'h0c: rdata_ff <= {20'h0, entry_ff[3]};
                default: rdata_ff <= 32'h00000000;
            endcase
        end
    end
    assign reg_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // Trigger synchroniser and millisecond tick
    // ----------------------------------------------------------------
    logic trg_s1_ff, trg_s2_ff, trg_d_ff, trg_rise, accept, tick;
    logic [16:0] div_ff;
    logic [15:0] now_ff, el_ff;
    jct_job_st_t job_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trg_s1_ff <= 1'b0;
            trg_s2_ff <= 1'b0;
            trg_d_ff <= 1'b0;
        end else begin
            trg_s1_ff <= trigger_pin;
            trg_s2_ff <= trg_s1_ff;
            trg_d_ff <= trg_s2_ff;
        end
    end
    assign trg_rise = trg_s2_ff & ~trg_d_ff;
    assign accept = trg_rise && job_ff == J_IDLE;

    // millisecond tick divider
    // Restarted on accept so job times are exact to one clock
    always_ff @(posedge ref_clk) begin
        if (srst || accept || tick) begin
            div_ff <= 17'h00000;
        end else begin
            div_ff <= div_ff + 17'h00001;
        end
    end
    assign tick = div_ff == 17'(MS_CYCLES - 1);

    // Free running time base for ejector due times
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            now_ff <= 16'h0000;
        end else if (tick) begin
            now_ff <= now_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Job cycle control
    // ----------------------------------------------------------------
    logic min_done, max_hit, res_upd;

    always_ff @(posedge ref_clk) begin
        if (srst || accept) begin
            el_ff <= 16'h0000;
        end else if (tick && el_ff != 16'hffff) begin
            el_ff <= el_ff + 16'h0001;
        end
    end

    assign min_done = !ctrl_ff[`JCT_CTRL_CYC_EN] || el_ff >= min_ff;
    assign max_hit = ctrl_ff[`JCT_CTRL_CYC_EN] && max_ff != 16'h0000 && el_ff >= max_ff;
    assign res_upd = job_ff == J_BUSY && (eval_done || max_hit);

    // Job sequencer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            job_ff <= J_IDLE;
        end else begin
            unique case (job_ff)
                J_IDLE: if (accept) job_ff <= J_BUSY;
                J_BUSY: if (res_upd) job_ff <= min_done ? J_IDLE : J_HOLD;
                J_HOLD: if (min_done) job_ff <= J_IDLE;
            endcase
        end
    end

    // Ready and Valid
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ready_ff <= 1'b1;
            valid_ff <= 1'b0;
        end else if (accept) begin
            ready_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            if (res_upd) valid_ff <= 1'b1;
            if ((job_ff == J_BUSY && res_upd || job_ff == J_HOLD) && min_done) ready_ff <= 1'b1;
        end
    end

    // Result latch; an abort keeps only finished detector results
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ok_ff <= 1'b0;
            abort_ff <= 1'b0;
            det_ff <= 8'h00;
            exec_ff <= 16'h0000;
        end else if (res_upd) begin
            exec_ff <= el_ff;
            if (!eval_done) begin
                ok_ff <= 1'b0;
                abort_ff <= 1'b1;
                det_ff <= det_result & det_done;
            end else begin
                ok_ff <= eval_ok;
                abort_ff <= 1'b0;
                det_ff <= det_result;
            end
        end
    end

    assign job_start = accept;
    assign job_abort = res_upd && !eval_done;

    // ----------------------------------------------------------------
    // Delayed ejector queue
    // ----------------------------------------------------------------
    logic [15:0] due_ff [`JCT_QUEUE_DEPTH];
    logic [4:0] q_wr_ff, q_rd_ff;
    logic [15:0] ej_run_ff;
    logic q_push, q_room, q_pop;
    logic [15:0] q_late;

    // depth of 20 with multi mode, else one
    assign q_room = ctrl_ff[`JCT_CTRL_MULTI] ? q_cnt_ff < 5'(`JCT_QUEUE_DEPTH) : q_cnt_ff == 5'h00;
    assign q_push = res_upd && ctrl_ff[`JCT_CTRL_EJ_ONLY] && !(eval_done && eval_ok);
    assign q_late = now_ff - due_ff[q_rd_ff];
    assign q_pop = tick && q_cnt_ff != 5'h00 && ej_run_ff == 16'h0000 && !q_late[15];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_wr_ff <= 5'h00;
            q_rd_ff <= 5'h00;
            q_cnt_ff <= 5'h00;
        end else begin
            if (q_push && q_room) begin
                due_ff[q_wr_ff] <= now_ff + ej_dly_ff;
                q_wr_ff <= q_wr_ff == 5'(`JCT_QUEUE_DEPTH - 1) ? 5'h00 : q_wr_ff + 5'h01;
            end
            if (q_pop) q_rd_ff <= q_rd_ff == 5'(`JCT_QUEUE_DEPTH - 1) ? 5'h00 : q_rd_ff + 5'h01;
            q_cnt_ff <= q_cnt_ff + 5'(q_push && q_room) - 5'(q_pop);
        end
    end

    // Overflow is sticky; a new overflow wins over a write-one clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovf_ff <= 1'b0;
        end else if (q_push && !q_room) begin
            ovf_ff <= 1'b1;
        end else if (reg_wr && reg_addr == `JCT_REG_STATUS && reg_wdata[`JCT_STAT_OVF]) begin
            ovf_ff <= 1'b0;
        end
    end

    // Ejector pulse width in ms; immediate result when not delayed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ej_run_ff <= 16'h0000;
        end else if (q_pop) begin
            ej_run_ff <= ej_len_ff;
        end else if (tick && ej_run_ff != 16'h0000) begin
            ej_run_ff <= ej_run_ff - 16'h0001;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) eject_ff <= 1'b0;
        else eject_ff <= ctrl_ff[`JCT_CTRL_EJ_ONLY] ? ej_run_ff != 16'h0000 : valid_ff & ~ok_ff;
    end

    // sinking mode inverts all levels, same register stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pins <= '0;
        end else begin
            pins <= {ready_ff, valid_ff, ok_ff, eject_ff, det_ff} ^ {12{ctrl_ff[`JCT_CTRL_SINK]}};
        end
    end

    // ----------------------------------------------------------------
    // Telegram framer
    // ----------------------------------------------------------------
    jct_tx_st_t ts_ff;
    logic [3:0] fi_ff;
    logic [1:0] pi_ff;
    logic [3:0] oi_ff, ci_ff;
    logic [4:0] pos_ff;
    logic [15:0] v_ff;
    logic [3:0] n_ff, m_ff;
    logic in_pay_ff, tel_pend_ff, eot_pend_ff;
    logic [7:0] chk_ff, nvals;
    logic ascii, fire, lst_end;
    logic [25:0] lst;
    logic [3:0] total, len, pad, k, sh;
    logic [7:0] ch;
    logic [11:0] ent;
    logic [3:0] ocnt;

    function automatic logic [7:0] hexc(input logic [3:0] d);
        hexc = d < 4'ha ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
    endfunction

    assign ascii = ctrl_ff[`JCT_CTRL_ASCII];
    assign ent = entry_ff[pi_ff];
    assign ocnt = ent[11:8] == 4'h0 ? 4'h1 : ent[11:8];
    assign val_sel = {ent[3:1], oi_ff};

    // Payload value count for the data length field
    always_comb begin
        nvals = 8'h00;
        for (int i = 0; i < `JCT_N_ENTRY; i++) begin
            if (entry_ff[i][0]) nvals = nvals + {4'h0, entry_ff[i][11:8] == 4'h0 ? 4'h1 : entry_ff[i][11:8]};
        end
    end

    // Character list of the current list state; EOT may go out as hex text
    always_comb begin
        unique case (ts_ff)
            T_START: lst = start_ff;
            T_TRAIL: lst = trail_ff;
            T_SEP: lst = sep_ff;
            default: lst = eot_ff;
        endcase
        total = (ts_ff == T_EOT && ctrl_ff[`JCT_CTRL_EOT_HEX]) ? {1'b0, lst[25:24], 1'b0} : {2'b00, lst[25:24]};
        lst_end = ci_ff >= total;
        len = m_ff > n_ff ? m_ff : n_ff;
        pad = len - n_ff;
        k = pos_ff[3:0] - pad;
        sh = n_ff - 4'h1 - k;
        ch = 8'h00;
        if (ts_ff == T_EMIT) begin
            if (pos_ff[3:0] < pad) ch = ascii ? 8'h20 : 8'h00;
            else if (ascii) ch = hexc(4'(v_ff >> {sh, 2'b00}));
            else ch = 8'(v_ff >> {sh, 3'b000});
        end else if (ts_ff == T_EOT && ctrl_ff[`JCT_CTRL_EOT_HEX]) begin
            ch = hexc(4'(lst >> {ci_ff[2:1], ~ci_ff[0], 2'b00}));
        end else begin
            ch = 8'(lst >> {ci_ff[1:0], 3'b000});
        end
    end

    assign tx.valid = ts_ff == T_EMIT || ((ts_ff == T_START || ts_ff == T_TRAIL || ts_ff == T_SEP
                      || ts_ff == T_EOT) && !lst_end);
    assign tx.data = ch;
    assign fire = tx.valid && tx_ready;

    // Pending requests; a new request wins over the clear on start
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tel_pend_ff <= 1'b0;
            eot_pend_ff <= 1'b0;
        end else begin
            if (res_upd) tel_pend_ff <= 1'b1;
            else if (ts_ff == T_IDLE) tel_pend_ff <= 1'b0;
            // end characters on responses, ASCII only
            if (resp_end && ascii) eot_pend_ff <= 1'b1;
            else if (ts_ff == T_IDLE && !tel_pend_ff) eot_pend_ff <= 1'b0;
        end
    end

    // Running byte sum for the checksum field
    always_ff @(posedge ref_clk) begin
        if (srst || ts_ff == T_IDLE) chk_ff <= 8'h00;
        else if (fire) chk_ff <= chk_ff + ch;
    end

    // Framer sequencer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ts_ff <= T_IDLE;
            fi_ff <= 4'h0;
            pi_ff <= 2'h0;
            oi_ff <= 4'h0;
            ci_ff <= 4'h0;
            pos_ff <= 5'h00;
            v_ff <= 16'h0000;
            n_ff <= 4'h1;
            m_ff <= 4'h0;
            in_pay_ff <= 1'b0;
        end else begin
            unique case (ts_ff)
                T_IDLE: begin
                    ci_ff <= 4'h0;
                    fi_ff <= 4'h0;
                    pi_ff <= 2'h0;
                    oi_ff <= 4'h0;
                    in_pay_ff <= 1'b0;
                    if (tel_pend_ff) ts_ff <= T_START;
                    else if (eot_pend_ff) ts_ff <= T_EOT;
                end
                T_START, T_SEP: begin
                    if (lst_end) begin
                        ci_ff <= 4'h0;
                        ts_ff <= (ts_ff == T_SEP && in_pay_ff) ? T_PAY : T_FIELD;
                    end else if (fire) ci_ff <= ci_ff + 4'h1;
                end
                T_FIELD: begin
                    pos_ff <= 5'h00;
                    m_ff <= 4'h0;
                    if (fi_ff == 4'(`JCT_N_FIELD)) begin
                        in_pay_ff <= 1'b1;
                        ts_ff <= T_PAY;
                    end else begin
                        fi_ff <= fi_ff + 4'h1;
                        if (fields_ff[fi_ff]) begin
                            ts_ff <= T_EMIT;
                            n_ff <= (fi_ff == 4'h0 || fi_ff == 4'h6) ? (ascii ? 4'h4 : 4'h2) : (ascii ? 4'h2 : 4'h1);
                            unique case (fi_ff)
                                4'h0: v_ff <= {7'h00, fields_ff};
                                4'h1: v_ff <= {8'h00, nvals};
                                4'h2: v_ff <= {14'h0000, abort_ff, ok_ff};
                                4'h3: v_ff <= {8'h00, det_ff};
                                4'h4: v_ff <= {8'h00, dig_outs};
                                4'h5: v_ff <= {8'h00, log_outs};
                                4'h6: v_ff <= exec_ff;
                                4'h7: v_ff <= {8'h00, jobno_ff};
                                default: v_ff <= {8'h00, chk_ff};
                            endcase
                        end
                    end
                end
                T_PAY: begin
                    pos_ff <= 5'h00;
                    if (!ent[0] || oi_ff >= ocnt) begin
                        oi_ff <= 4'h0;
                        pi_ff <= pi_ff + 2'h1;
                        if (pi_ff == 2'(`JCT_N_ENTRY - 1)) ts_ff <= T_TRAIL;
                    end else begin
                        v_ff <= val_data;
                        n_ff <= ascii ? 4'h4 : 4'h2;
                        m_ff <= ent[7:4];
                        oi_ff <= oi_ff + 4'h1;
                        ts_ff <= T_EMIT;
                    end
                end
                T_EMIT: begin
                    if (fire) begin
                        pos_ff <= pos_ff + 5'h01;
                        if (pos_ff[3:0] == len - 4'h1) begin
                            ts_ff <= ascii ? T_SEP : (in_pay_ff ? T_PAY : T_FIELD);
                            ci_ff <= 4'h0;
                        end
                    end
                end
                T_TRAIL, T_EOT: begin
                    if (lst_end) ts_ff <= T_IDLE;
                    else if (fire) ci_ff <= ci_ff + 4'h1;
                end
            endcase
        end
    end

endmodule // jct_top

// ===== common/jct_consts.svh
// Offsets, field positions, reset values and timing counts of the job-cycle and telegram block
//
// Summary of operation
// - Triggers inside minimum job time are discarded
// - Maximum job time aborts job, result not OK
// - Unfinished detectors forced false on abort
// - Cycle time runs trigger to output update
// - Outputs and Valid update right after evaluation
// - Ready held low until minimum time elapsed
// - Up to 20 pending delayed ejector pulses
// - Ejector queue only in ejector-only delay mode
// - Telegram encoding selectable binary or ASCII
// - Start characters precede the payload
// - Trailer characters follow the payload
// - Separator after each value, ASCII only
// - End characters only on command responses, ASCII only
// - Standard fields emitted in fixed order
// - Selected-fields item shows enabled fields
// - Short values padded: spaces or zeros
// - Only active entries, in list order
// - Up to configured per-object values emitted
// - Accepted trigger drops Ready and Valid
// - Sinking mode inverts every output level
`ifndef JCT_CONSTS_SVH
`define JCT_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define JCT_REG_CTRL 8'h00
`define JCT_REG_FIELDS 8'h04
`define JCT_REG_MIN_MS 8'h08
`define JCT_REG_MAX_MS 8'h0c
`define JCT_REG_EJECT 8'h10
`define JCT_REG_START 8'h14
`define JCT_REG_TRAIL 8'h18
`define JCT_REG_SEP 8'h1c
`define JCT_REG_EOT 8'h20
`define JCT_REG_JOBNO 8'h24
`define JCT_REG_STATUS 8'h28
`define JCT_REG_EXEC 8'h2c
`define JCT_REG_ENTRY0 8'h30

// ----------------------------------------------------------------
// Control bits and sizes
// ----------------------------------------------------------------
`define JCT_CTRL_CYC_EN 0
`define JCT_CTRL_ASCII 1
`define JCT_CTRL_EJ_ONLY 2
`define JCT_CTRL_MULTI 3
`define JCT_CTRL_SINK 4
`define JCT_CTRL_EOT_HEX 5
`define JCT_STAT_OVF 4
`define JCT_CTRL_RST 6'h00
`define JCT_FIELDS_RST 9'h000
`define JCT_QUEUE_DEPTH 20
`define JCT_N_ENTRY 4
`define JCT_N_FIELD 9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define JCT_CLK_PERIOD_NS 10
`define JCT_MS_NS 1000000
`define JCT_MS_CYCLES (`JCT_MS_NS / `JCT_CLK_PERIOD_NS)

`endif

// ===== common/jct_pkg.sv
// Types shared by the job-cycle and telegram block
package jct_pkg;

    // Result output group, one bit per pin
    typedef struct packed {
        logic ready;
        logic valid;
        logic ok;
        logic ejector;
        logic [7:0] det;
    } jct_out_t;

    // Telegram byte stream toward the transport
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } jct_tx_t;

    typedef enum {J_IDLE, J_BUSY, J_HOLD} jct_job_st_t;

    typedef enum {T_IDLE, T_START, T_FIELD, T_PAY, T_EMIT, T_SEP, T_TRAIL, T_EOT} jct_tx_st_t;

endpackage

// ===== verif/jct_monitor.sv
// Port-level checks for the job-cycle and telegram block
module jct_monitor #(parameter int MS_CYCLES = 10) (
    input wire logic ref_clk, input wire logic srst, input wire logic eval_done, input wire logic eval_ok,
    input wire logic [7:0] det_done, input wire logic [7:0] det_result, input wire logic tx_ready,
    input wire logic [7:0] reg_addr, input wire logic [31:0] reg_wdata, input wire logic reg_wr,
    input wire logic job_start, input wire logic job_abort,
    input wire jct_pkg::jct_out_t pins, input wire jct_pkg::jct_tx_t tx
);
    timeunit 1ns;
    timeprecision 1ps;
    import jct_pkg::*;
    logic sink_ff, sink_d_ff, busy_ff;
    logic [15:0] min_ff, el_ff;
    logic [11:0] lv;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Pins seen in sourcing sense; the sink bit reaches the pins a cycle late
    assign lv = pins ^ {12{sink_d_ff}};
    // Shadow of sink and minimum time, cycles since accept, job in flight
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {sink_ff, sink_d_ff, busy_ff, min_ff, el_ff} <= {3'h0, 16'h0000, 16'hffff};
        end else begin
            sink_d_ff <= sink_ff;
            if (reg_wr && reg_addr == 8'h00) sink_ff <= reg_wdata[4];
            if (reg_wr && reg_addr == 8'h08) min_ff <= reg_wdata[15:0];
            el_ff <= job_start ? 16'h0001 : el_ff + {15'h0, el_ff != 16'hffff};
            busy_ff <= job_start | (busy_ff & ~eval_done & ~job_abort);
        end
    end
    AST_START_DROP: assert property (job_start |-> ##2 (!lv[11] && !lv[10]))
        else $error("ready or valid high after accept");
    AST_ABORT_NOK: assert property (job_abort |-> ##2 (lv[10] && !lv[9]))
        else $error("abort result not marked bad");
    AST_ABORT_DET: assert property (job_abort |-> ##2 ((lv[7:0] & ~$past(det_done, 2)) == 8'h00))
        else $error("unfinished detector not cleared");
    AST_EVAL_RES: assert property (busy_ff && eval_done |-> ##2
        (lv[10] && lv[9] == $past(eval_ok, 2) && lv[7:0] == $past(det_result, 2))) else $error("late result");
    AST_ABORT_CAUSE: assert property (job_abort |-> busy_ff && !eval_done)
        else $error("abort outside a running job");
    AST_MIN_ACCEPT: assert property (job_start |-> 32'(el_ff) + 2 >= min_ff * MS_CYCLES)
        else $error("trigger taken inside minimum time");
    AST_READY_MIN: assert property ($rose(lv[11]) |-> 32'(el_ff) + 3 >= min_ff * MS_CYCLES)
        else $error("ready before minimum time");
    AST_TX_HOLD: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("telegram byte dropped under stall");
endmodule // jct_monitor

// ===== verif/jct_plc_model.sv
// Far side: evaluation engine answers and a stalling telegram sink
module jct_plc_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic job_start,
    input wire logic [6:0] val_sel,
    output logic eval_done = 1'b0,
    output logic eval_ok,
    output logic [7:0] det_done,
    output logic [7:0] det_result,
    output logic [15:0] val_data,
    output logic tx_ready = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lat = 8'h03; // Zero means evaluation never ends
    logic [7:0] cnt = 8'h00;
    logic [2:0] stall = 3'h0;
    // Half the detectors stay unfinished until the evaluation ends
    assign det_done = eval_done ? 8'hff : 8'h0f;
    assign {eval_ok, det_result, val_data} = {1'b1, 8'h5a, 8'hab, 1'b0, val_sel};
    // Countdown to the finish pulse; sink stalls two of every eight cycles
    always @(posedge ref_clk) begin
        stall <= stall + 3'h1;
        tx_ready <= stall != 3'h3 && stall != 3'h4;
        eval_done <= !srst && !job_start && cnt == 8'h01;
        cnt <= srst ? 8'h00 : job_start ? lat : cnt - {7'h0, cnt != 8'h00};
    end
endmodule // jct_plc_model

// ===== verif/jct_top_tb.sv
// Bench: register access, job timing and telegram content
module jct_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jct_pkg::*;
    logic ref_clk = 0, srst = 1, trigger_pin = 0, resp_end = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] dig_outs = 8'h81, log_outs = 8'h42, reg_addr = 8'h00, det_done, det_result, rx[$];
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic eval_done, eval_ok, tx_ready, job_start, job_abort;
    logic [15:0] val_data;
    logic [11:0] p;
    logic [6:0] val_sel;
    jct_out_t pins;
    jct_tx_t tx;
    int miscompares = 0, num_checks = 0, cyc = 0, starts = 0;
    jct_top #(.MS_CYCLES(10)) u_dut (.*);
    jct_plc_model u_plc (.*);
    always #5 ref_clk = ~ref_clk;
    // Byte capture, accept count and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (tx.valid === 1'b1 && tx_ready === 1'b1) rx.push_back(tx.data);
        if (job_start === 1'b1) starts <= starts + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task automatic tel(input logic [7:0] e[$]);
        chk(rx.size(), e.size());
        foreach (e[i]) chk(rx[i], e[i]);
        rx.delete();
    endtask
    // Two trigger pulses; the second lands inside the minimum time
    task automatic job(input logic [7:0] lat);
        u_plc.lat = lat;
        repeat (2) begin
            @(posedge ref_clk);
            trigger_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            trigger_pin <= 1'b0;
            repeat (8) @(posedge ref_clk);
            chk(pins.ready, 0);
        end
        for (int i = 0; i < 3000 && pins.ready !== 1'b1; i++) @(posedge ref_clk);
        repeat (80) @(posedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        rd(8'h10, 32'h0001_0000);
        rd(8'h40, 32'h0);
        wr(8'h14, 32'h0100_0002);
        wr(8'h18, 32'h0100_0003);
        wr(8'h1c, 32'h0100_002c);
        wr(8'h20, 32'h0200_0a0d);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h4);
        wr(8'h30, 32'h61);
        rx.delete();
        job(8'h03);
        chk(pins, 12'he5a);
        tel('{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hab, 8'h00, 8'h03});
        wr(8'h0c, 32'h2);
        wr(8'h00, 32'hd);
        job(8'h00);
        chk(starts, 2);
        rd(8'h28, 32'h0000_000b);
        chk(pins, 12'hc0a);
        tel('{8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'hab, 8'h00, 8'h03});
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            resp_end <= 1'b1;
            @(posedge ref_clk);
            resp_end <= 1'b0;
            repeat (30) @(posedge ref_clk);
            wr(8'h00, i ? 32'h23 : 32'h3);
        end
        tel('{8'h0d, 8'h0a, 8'h30, 8'h44, 8'h30, 8'h41});
        wr(8'h0c, 32'h0);
        job(8'h03);
        tel('{8'h02, 8'h30, 8'h31, 8'h2c, 8'h20, 8'h20, 8'h41, 8'h42, 8'h30, 8'h30, 8'h2c, 8'h03});
        p = pins;
        wr(8'h00, 32'h13);
        repeat (3) @(posedge ref_clk);
        chk(pins, 12'(~p));
        tally_and_finish();
    end
endmodule // jct_top_tb
bind jct_top jct_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.*);
